// [bench/bmc_alu_props.sv]
// assertions on the ports of the datapath
`timescale 1ns/1ps
module bmc_alu_props #(parameter int XLEN = 32) (
  input wire logic clock_in, rst_in, valid_in,
  input wire logic [6:0] opcode_in, funct7_in,
  input wire logic [2:0] funct3_in,
  input wire logic [4:0] rs2_field_in,
  input wire logic [5:0] shamt_in,
  input wire logic [XLEN-1:0] src1_in, src2_in, result_out,
  input wire logic valid_out, hit_out, illegal_out
);
  localparam int IW = $clog2(XLEN);
  wire logic imm = valid_in && opcode_in == bmc_pkg::OPC_OP_IMM;
  wire logic rop = valid_in && opcode_in == bmc_pkg::OPC_OP && funct3_in == bmc_pkg::F3_BIT_SET;
  wire logic clz = imm && funct3_in == bmc_pkg::F3_CLZ && funct7_in == bmc_pkg::F7_COUNT
                   && rs2_field_in == bmc_pkg::RS2_CLZ;
  wire logic ext = imm && funct3_in == bmc_pkg::F3_BIT_EXT && funct7_in[6:1] == 6'h12;
  wire logic bim = imm && ((funct3_in == bmc_pkg::F3_BIT_EXT
                   && funct7_in[6:1] == bmc_pkg::F7_EXT[6:1])
                   || (funct3_in == bmc_pkg::F3_BIT_SET
                   && (funct7_in[6:1] == bmc_pkg::F7_INV[6:1]
                   || funct7_in[6:1] == bmc_pkg::F7_SET[6:1])));
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_clz_empty: assert property (clz && src1_in == '0 |-> result_out == XLEN)
    else $error("leading zero count of zero wrong");
  a_clz_top: assert property (clz && src1_in[XLEN-1] |-> result_out == '0)
    else $error("leading zero count with top bit set wrong");
  a_ext_bit: assert property (ext && !illegal_out |-> result_out ==
    {{(XLEN-1){1'b0}}, src1_in[shamt_in[IW-1:0]]}) else $error("extract wrong");
  a_reserved_imm: assert property (bim && shamt_in[5] && XLEN == 32 |-> illegal_out
    && !hit_out) else $error("reserved immediate executed");
  a_miss_zero: assert property (!hit_out |-> result_out == '0)
    else $error("result not zero on miss");
  a_inv_reg: assert property (rop && funct7_in == bmc_pkg::F7_INV |-> result_out ==
    (src1_in ^ (XLEN'(1) << src2_in[IW-1:0]))) else $error("register invert wrong");
  a_set_reg: assert property (rop && funct7_in == bmc_pkg::F7_SET |-> result_out ==
    (src1_in | (XLEN'(1) << src2_in[IW-1:0]))) else $error("register set wrong");
  a_valid_echo: assert property (valid_out == valid_in)
    else $error("valid not echoed");
endmodule : bmc_alu_props
bind bmc_alu bmc_alu_props #(.XLEN(XLEN)) bmc_alu_props_i (.clock_in, .rst_in, .valid_in,
  .opcode_in, .funct7_in, .funct3_in, .rs2_field_in, .shamt_in, .src1_in, .src2_in,
  .result_out, .valid_out, .hit_out, .illegal_out);

// [bench/bmc_issue_model.sv]
// issue stage model that presents one decoded operation per clock
`timescale 1ns/1ps
module bmc_issue_model (
  // clock
  input  wire logic        clock_in,
  // request from the bench, presented one edge later
  input  wire logic [92:0] req_in,
  output logic      [92:0] issue_out = '0
);
  always @(posedge clock_in) begin
    issue_out <= req_in;
  end
endmodule : bmc_issue_model

// [bench/tb_top.sv]
// self-checking bench for the bit-manipulation datapath
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [6:0] op; logic [2:0] f3; logic [6:0] f7; logic [5:0] sh;
    logic [31:0] a, b, exp; logic hit, ill;
  } bmc_row_s;
  localparam logic [6:0] OI = bmc_pkg::OPC_OP_IMM;
  localparam logic [6:0] OP = bmc_pkg::OPC_OP;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [92:0] req = '0;
  logic [92:0] iss;
  logic valid_in, valid_out, hit_out, illegal_out;
  logic [6:0] opcode_in, funct7_in;
  logic [2:0] funct3_in;
  logic [4:0] rs2_field_in;
  logic [5:0] shamt_in;
  logic [31:0] src1_in, src2_in, result_out;
  int err_total = 0;
  int comparisons = 0;
  bmc_row_s rows [14];
  always #2.5 clock_in = ~clock_in;
  assign {valid_in, opcode_in, funct3_in, funct7_in, rs2_field_in, shamt_in, src1_in,
          src2_in} = iss;
  bmc_issue_model bmc_issue_model_i (.clock_in, .req_in(req), .issue_out(iss));
  bmc_alu #(.XLEN(32)) bmc_alu_i (.clock_in, .rst_in, .valid_in, .opcode_in, .funct3_in,
    .funct7_in, .rs2_field_in, .shamt_in, .src1_in, .src2_in, .valid_out, .hit_out,
    .illegal_out, .result_out);
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t result %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // request goes out one edge later through the issue model; sample mid-cycle
  task automatic issue(input bmc_row_s r, input logic v);
    @(posedge clock_in);
    req <= {v, r.op, r.f3, r.f7, r.sh[4:0], r.sh, r.a, r.b};
    @(posedge clock_in);
    @(negedge clock_in);
  endtask : issue
  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
  initial begin
    rows = '{
      '{OI, 3'h5, 7'h24, 6'h03, 32'h8, 32'h0, 32'h1, 1'b1, 1'b0},
      '{OI, 3'h1, 7'h34, 6'h1F, 32'h0, 32'h0, 32'h8000_0000, 1'b1, 1'b0},
      '{OI, 3'h1, 7'h14, 6'h00, 32'hF0, 32'h0, 32'hF1, 1'b1, 1'b0},
      '{OP, 3'h1, 7'h34, 6'h00, 32'hFF, 32'hFFFF_FFE3, 32'hF7, 1'b1, 1'b0},
      '{OP, 3'h1, 7'h14, 6'h00, 32'h0, 32'h20, 32'h1, 1'b1, 1'b0},
      '{OP, 3'h1, 7'h05, 6'h00, '1, '1, 32'h5555_5555, 1'b1, 1'b0},
      '{OP, 3'h3, 7'h05, 6'h00, '1, '1, 32'h5555_5555, 1'b1, 1'b0},
      '{OP, 3'h2, 7'h05, 6'h00, '1, '1, 32'hAAAA_AAAA, 1'b1, 1'b0},
      '{OP, 3'h2, 7'h05, 6'h00, 32'h8000_0001, 32'h3, 32'h3, 1'b1, 1'b0},
      '{OI, 3'h1, 7'h30, 6'h00, 32'h0, 32'h0, 32'h20, 1'b1, 1'b0},
      '{OI, 3'h1, 7'h30, 6'h00, 32'h0001_0000, 32'h0, 32'hF, 1'b1, 1'b0},
      '{OI, 3'h1, 7'h30, 6'h00, 32'h8000_0000, 32'h0, 32'h0, 1'b1, 1'b0},
      '{OI, 3'h1, 7'h15, 6'h21, 32'hF0, 32'h0, 32'h0, 1'b0, 1'b1},
      '{OP, 3'h1, 7'h7F, 6'h00, 32'hF0, 32'h1, 32'h0, 1'b0, 1'b0}};
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      issue(rows[i], 1'b1);
      chk_word(result_out, rows[i].exp);
      chk_bit(hit_out, rows[i].hit);
      chk_bit(illegal_out, rows[i].ill);
    end
    // idle slot, then an operation right after it must not see leftovers
    issue(rows[0], 1'b0);
    chk_bit(valid_out, 1'b0);
    chk_bit(hit_out, 1'b0);
    chk_word(result_out, 32'h0);
    issue(rows[5], 1'b1);
    chk_word(result_out, 32'h5555_5555);
    complete_run();
  end
endmodule : tb_top

// [src/bmc_alu.sv]
// bit-manipulation and carry-less execution datapath
// What this block does
// RL1 - immediate extract puts indexed operand bit in bit 0, others zero
// RL2 - immediate forms use only low log2(XLEN) bits of the immediate
// RL3 - register forms use only low log2(XLEN) bits of operand two
// RL4 - on 32-bit, immediate forms with immediate bit 5 set are reserved
// RL5 - register invert toggles exactly the indexed bit
// RL6 - immediate invert xors operand one with one shifted by index
// RL7 - register set forces the indexed bit to one
// RL8 - immediate set ors operand one with one shifted by index
// RL9 - low carry-less multiply returns low half of product
// RL10 - high carry-less multiply returns upper half of product
// RL11 - reversed multiply returns product bits 2XLEN-2 down to XLEN-1
// RL12 - reversed equals reversed operands, low product, reversed result
// RL13 - leading zero count runs from the top bit to the first one
// RL14 - zero source gives XLEN, top bit set gives zero
// RL15 - crypto subset drops the reversed multiply
// RL16 - operation decoded from opcode, funct3, funct7 fields
// RL17 - no state held between operations
`timescale 1ns/1ps
module bmc_alu #(
  parameter int XLEN      = bmc_pkg::XLEN_DEFAULT,
  // 0 leaves out the reversed multiply, as in the crypto subset
  parameter bit HAS_CLMULR = 1'b1,
  // 1 registers the outputs: one cycle later, and rst_in comes into use
  parameter bit PIPELINED  = 1'b0
) (
  // clock and reset
  input  wire logic            clock_in,
  input  wire logic            rst_in,
  // decoded instruction
  input  wire logic            valid_in,
  input  wire logic [6:0]      opcode_in,
  input  wire logic [2:0]      funct3_in,
  input  wire logic [6:0]      funct7_in,
  input  wire logic [4:0]      rs2_field_in,
  input  wire logic [5:0]      shamt_in,
  // operands
  input  wire logic [XLEN-1:0] src1_in,
  input  wire logic [XLEN-1:0] src2_in,
  // result
  output logic                 valid_out,
  output logic                 hit_out,
  output logic                 illegal_out,
  output logic [XLEN-1:0]      result_out
);
  localparam int IW = $clog2(XLEN);

  // decode; funct3 alone is shared, so every kind needs its funct7; immediate extract, invert and set match only bits 6:1
  logic       is_op;
  logic       is_imm;
  logic [6:0] f7_imm;
  logic       imm_res;
  logic       d_exti;
  logic       d_invi;
  logic       d_seti;
  logic       d_clz;
  logic       d_inv;
  logic       d_set;
  logic       d_cm;
  logic       d_cml;
  logic       d_cmh;
  logic       d_cmr;
  logic       any_imm;
  logic       illegal;

  assign is_op   = opcode_in == bmc_pkg::OPC_OP;     // [RL16]
  assign is_imm  = opcode_in == bmc_pkg::OPC_OP_IMM; // [RL16]
  // 64-bit immediates steal funct7 bit 0 for shamt bit 5
  assign f7_imm  = {funct7_in[6:bmc_pkg::F7_SHAMT_LO], 1'b0};
  // only the 32-bit build has a shamt bit 5 that must be refused
  assign imm_res = (XLEN == 32) && shamt_in[bmc_pkg::SHAMT_HI];
  assign d_exti  = is_imm
                   && funct3_in == bmc_pkg::F3_BIT_EXT
                   && f7_imm == bmc_pkg::F7_EXT;
  assign d_invi  = is_imm
                   && funct3_in == bmc_pkg::F3_BIT_SET
                   && f7_imm == bmc_pkg::F7_INV;
  assign d_seti  = is_imm
                   && funct3_in == bmc_pkg::F3_BIT_SET
                   && f7_imm == bmc_pkg::F7_SET;
  // clz shares funct3 with invi and seti; funct7 and rs2 split them
  assign d_clz   = is_imm
                   && funct3_in == bmc_pkg::F3_CLZ
                   && funct7_in == bmc_pkg::F7_COUNT
                   && rs2_field_in == bmc_pkg::RS2_CLZ;
  assign d_inv   = is_op
                   && funct3_in == bmc_pkg::F3_BIT_SET
                   && funct7_in == bmc_pkg::F7_INV;
  assign d_set   = is_op
                   && funct3_in == bmc_pkg::F3_BIT_SET
                   && funct7_in == bmc_pkg::F7_SET;
  assign d_cm    = is_op && funct7_in == bmc_pkg::F7_CLMUL;
  assign d_cml   = d_cm && funct3_in == bmc_pkg::F3_CLMUL;
  assign d_cmh   = d_cm && funct3_in == bmc_pkg::F3_CLMULH;
  // crypto subset: the reversed form falls through as an unknown encoding
  assign d_cmr   = d_cm && funct3_in == bmc_pkg::F3_CLMULR && HAS_CLMULR; // [RL15]
  assign any_imm = d_exti || d_invi || d_seti;
  assign illegal = any_imm && imm_res; // [RL4]

  bmc_pkg::bmc_op_e op;
  assign op = illegal ? bmc_pkg::BMC_OP_NONE :
              d_exti ? bmc_pkg::BMC_OP_EXTI :
              d_invi ? bmc_pkg::BMC_OP_INVI :
              d_seti ? bmc_pkg::BMC_OP_SETI :
              d_inv  ? bmc_pkg::BMC_OP_INV  :
              d_set  ? bmc_pkg::BMC_OP_SET  :
              d_cml  ? bmc_pkg::BMC_OP_CLMUL :
              d_cmh  ? bmc_pkg::BMC_OP_CLMULH :
              d_cmr  ? bmc_pkg::BMC_OP_CLMULR :
              d_clz  ? bmc_pkg::BMC_OP_CLZ : bmc_pkg::BMC_OP_NONE;

  // bit index and one-hot mask
  logic [IW-1:0]   idx_imm;
  logic [IW-1:0]   idx_reg;
  logic            idx_sel_reg;
  logic [IW-1:0]   idx;
  logic [XLEN-1:0] onehot;
  assign idx_imm     = shamt_in[IW-1:0]; // [RL2]
  assign idx_reg     = src2_in[IW-1:0];  // [RL3]
  assign idx_sel_reg = op == bmc_pkg::BMC_OP_INV || op == bmc_pkg::BMC_OP_SET;
  assign idx         = idx_sel_reg ? idx_reg : idx_imm;
  // upper operand bits never reach the shifter, so no index is out of range
  assign onehot      = {{(XLEN-1){1'b0}}, 1'b1} << idx;

  // carry-less product; reversed form reuses it by bit reversal
  logic [XLEN-1:0] a_rev;
  logic [XLEN-1:0] b_rev;
  logic [XLEN-1:0] lo_rev;
  logic            rev;
  bmc_clmul_if #(.XLEN(XLEN)) cm ();
  bmc_clmul #(.XLEN(XLEN)) u_clmul (.port(cm.provider));
  assign rev  = op == bmc_pkg::BMC_OP_CLMULR;
  // one shared array, traded for a mux level in front of it
  assign cm.a = rev ? a_rev : src1_in;
  assign cm.b = rev ? b_rev : src2_in;
  for (genvar i = 0; i < XLEN; i++) begin : g_rev
    assign a_rev[i]  = src1_in[XLEN-1-i];
    assign b_rev[i]  = src2_in[XLEN-1-i];
    assign lo_rev[i] = cm.prod[XLEN-1-i]; // [RL12] [RL11]
  end

  // leading zero count, scan from the top
  // the first one found freezes the count; an all-zero source keeps XLEN
  logic [IW:0] lz;
  logic        seen;
  always_comb begin
    lz   = (IW+1)'(XLEN); // [RL14]
    seen = 1'b0;
    for (int i = XLEN-1; i >= 0; i--) begin
      if (!seen && src1_in[i]) begin
        lz   = (IW+1)'(XLEN-1-i); // [RL13]
        seen = 1'b1;
      end
    end
  end

  // result select; per-kind results are named so the case stays a plain pick
  logic [XLEN-1:0] res_ext;
  logic [XLEN-1:0] res_inv;
  logic [XLEN-1:0] res_set;
  logic [XLEN-1:0] res_clz;
  logic [XLEN-1:0] res;
  assign res_ext = {{(XLEN-1){1'b0}}, src1_in[idx]}; // [RL1]
  assign res_inv = src1_in ^ onehot;                  // [RL5] [RL6]
  assign res_set = src1_in | onehot;                  // [RL7] [RL8]
  assign res_clz = {{(XLEN-IW-1){1'b0}}, lz};         // [RL13] [RL14]
  always_comb begin
    unique case (op)
      bmc_pkg::BMC_OP_EXTI:   res = res_ext;                // [RL1]
      bmc_pkg::BMC_OP_INV:    res = res_inv;                // [RL5]
      bmc_pkg::BMC_OP_INVI:   res = res_inv;                // [RL6]
      bmc_pkg::BMC_OP_SET:    res = res_set;                // [RL7]
      bmc_pkg::BMC_OP_SETI:   res = res_set;                // [RL8]
      bmc_pkg::BMC_OP_CLMUL:  res = cm.prod[XLEN-1:0];      // [RL9]
      bmc_pkg::BMC_OP_CLMULH: res = cm.prod[2*XLEN-1:XLEN]; // [RL10]
      bmc_pkg::BMC_OP_CLMULR: res = lo_rev;                 // [RL11]
      bmc_pkg::BMC_OP_CLZ:    res = res_clz;                // [RL14]
      bmc_pkg::BMC_OP_NONE:   res = '0;
      default:                res = '0;
    endcase
  end

  // no operation and refused encodings both give a zero result
  logic hit;
  logic ill;
  assign hit = valid_in && op != bmc_pkg::BMC_OP_NONE;
  assign ill = valid_in && illegal;

  // optional output stage; holds only the current issue, nothing carried over
  // the registers ease timing at the cost of one cycle of latency
  if (PIPELINED) begin : g_pipe
    logic            v_q;
    logic            h_q;
    logic            i_q;
    logic [XLEN-1:0] r_q;
    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        v_q <= 1'b0;
        h_q <= 1'b0;
        i_q <= 1'b0;
        r_q <= '0;
      end else begin
        v_q <= valid_in;
        h_q <= hit;
        i_q <= ill;
        r_q <= hit ? res : '0; // [RL17]
      end
    end
    assign valid_out   = v_q;
    assign hit_out     = h_q;
    assign illegal_out = i_q;
    assign result_out  = r_q;
  end else begin : g_comb
    // combinational build: rst_in has no effect here
    assign valid_out   = valid_in;
    assign hit_out     = hit;
    assign illegal_out = ill;
    assign result_out  = hit ? res : '0; // [RL17]
  end
endmodule : bmc_alu

// [src/bmc_clmul.sv]
// full double-width carry-less product
`timescale 1ns/1ps
module bmc_clmul #(
  parameter int XLEN = 32
) (
  bmc_clmul_if.provider port
);
  logic [2*XLEN-1:0] part [XLEN+1];
  assign part[0] = '0;
  for (genvar i = 0; i < XLEN; i++) begin : g_row
    // xor of a shifted by i for every set bit i of b
    assign part[i+1] = part[i] ^
      (port.b[i] ? ({{XLEN{1'b0}}, port.a} << i) : '0);
  end
  assign port.prod = part[XLEN];
endmodule : bmc_clmul

// [src/bmc_if.sv]
// operand bundle between the datapath and its carry-less multiplier
`timescale 1ns/1ps
interface bmc_clmul_if #(parameter int XLEN = 32);
  logic [XLEN-1:0]   a;
  logic [XLEN-1:0]   b;
  logic [2*XLEN-1:0] prod;
  modport requester (output a, output b, input prod);
  modport provider  (input a, input b, output prod);
endinterface : bmc_clmul_if

// [src/bmc_pkg.sv]
// constants and encodings for the bit-manipulation and carry-less datapath
package bmc_pkg;
  localparam int XLEN_DEFAULT = 32;
  localparam logic [6:0] OPC_OP      = 7'h33;
  localparam logic [6:0] OPC_OP_IMM  = 7'h13;
  localparam logic [2:0] F3_BIT_SET  = 3'h1;
  localparam logic [2:0] F3_CLMUL    = 3'h1;
  localparam logic [2:0] F3_CLMULR   = 3'h2;
  localparam logic [2:0] F3_CLMULH   = 3'h3;
  localparam logic [2:0] F3_BIT_EXT  = 3'h5;
  localparam logic [2:0] F3_CLZ      = 3'h1;
  localparam logic [6:0] F7_SET      = 7'h14;
  localparam logic [6:0] F7_INV      = 7'h34;
  localparam logic [6:0] F7_EXT      = 7'h24;
  localparam logic [6:0] F7_CLMUL    = 7'h05;
  localparam logic [6:0] F7_COUNT    = 7'h30;
  localparam logic [4:0] RS2_CLZ     = 5'h00;
  localparam int         SHAMT_W     = 6;
  localparam int         SHAMT_HI    = 5;
  localparam int         F7_SHAMT_LO = 1;
  typedef enum logic [3:0] {
    BMC_OP_NONE, BMC_OP_EXTI, BMC_OP_INV, BMC_OP_INVI, BMC_OP_SET, BMC_OP_SETI,
    BMC_OP_CLMUL, BMC_OP_CLMULH, BMC_OP_CLMULR, BMC_OP_CLZ
  } bmc_op_e;
endpackage : bmc_pkg
